// ==== rtc_map.svh ====
// Offsets, field positions, reset values and timing counts of the clock map
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH

// ----------------------------------------------------------------------
// Map layout
// ----------------------------------------------------------------------
`define RTC_OFS_SEC 6'h00
`define RTC_OFS_SEC_ALM 6'h01
`define RTC_OFS_MIN 6'h02
`define RTC_OFS_MIN_ALM 6'h03
`define RTC_OFS_HR 6'h04
`define RTC_OFS_HR_ALM 6'h05
`define RTC_OFS_WDAY 6'h06
`define RTC_OFS_DATE 6'h07
`define RTC_OFS_MONTH 6'h08
`define RTC_OFS_YEAR 6'h09
`define RTC_OFS_A 6'h0a
`define RTC_OFS_B 6'h0b
`define RTC_OFS_C 6'h0c
`define RTC_OFS_D 6'h0d
`define RTC_TIME_BYTES 10
`define RTC_RAM_FIRST 14
`define RTC_RAM_LAST 63

// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define RTC_B_SET 7
`define RTC_B_AIE 5
`define RTC_B_UIE 4
`define RTC_B_SQ_EN 3
`define RTC_B_FMT 2
`define RTC_B_H24 1
`define RTC_DV_SLOW 3'h2
`define RTC_DONT_CARE 2'h3
`define RTC_A_RESET 7'h20
`define RTC_B_RESET 8'h02
`define RTC_D_VALUE 8'h80
`define RTC_UNDEF_DATA 8'hff

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RTC_CLK_HZ 10000000
`define RTC_LOCK_FAST_US 248
`define RTC_LOCK_SLOW_US 1948
`define RTC_SEC_CYCLES `RTC_CLK_HZ
`define RTC_LOCK_FAST_CYCLES (`RTC_LOCK_FAST_US * (`RTC_CLK_HZ / 1000000))
`define RTC_LOCK_SLOW_CYCLES (`RTC_LOCK_SLOW_US * (`RTC_CLK_HZ / 1000000))

`endif

// ==== rtc_pkg.sv ====
// Types and format helpers shared by the clock modules
`default_nettype none
package rtc_pkg;
    typedef enum logic [1:0] {UPD_IDLE, UPD_LOCK, UPD_APPLY} upd_state_t;

    // Byte in either format to a plain binary number
    function automatic logic [6:0] to_bin(input logic [7:0] v, input logic bin);
        logic [6:0] tens;
        tens = {3'h0, v[7:4]};
        return bin ? v[6:0] : 7'(tens * 7'h0a + {3'h0, v[3:0]});
    endfunction : to_bin

    // Plain binary number back to the selected format
    function automatic logic [7:0] from_bin(input logic [6:0] n, input logic bin);
        return bin ? {1'b0, n} : {4'(n / 7'h0a), 4'(n % 7'h0a)};
    endfunction : from_bin
endpackage : rtc_pkg
`default_nettype wire

// ==== rtc_field_step.sv ====
// One time field advanced by one step with wrap, in binary or BCD
`default_nettype none
module rtc_field_step
    import rtc_pkg::*;
(
    input wire logic [7:0] val,
    input wire logic bin,
    input wire logic [6:0] lo,
    input wire logic [6:0] hi,
    output logic [7:0] next,
    output logic wrap
);
    logic [6:0] b;

    // Work in binary so one limit pair serves both formats
    assign b = to_bin(val, bin);
    assign wrap = (b >= hi);
    assign next = from_bin(wrap ? lo : 7'(b + 7'h01), bin);
endmodule : rtc_field_step
`default_nettype wire

// ==== rtc_alarm_cmp.sv ====
// One alarm byte against its count byte, with the match-all code
`default_nettype none
`include "rtc_map.svh"
module rtc_alarm_cmp (
    input wire logic [7:0] alarm,
    input wire logic [7:0] count,
    output logic match
);
    assign match = (alarm[7:6] == `RTC_DONT_CARE) || (alarm == count);
endmodule : rtc_alarm_cmp
`default_nettype wire

// ==== rtc_core.sv ====
// Real-time clock core: time, calendar, alarm and RAM behind a multiplexed bus
//
// Behaviour
// [RQ1] Sixty-four bytes: time, control, fifty RAM
// [RQ2] Status, lockout and seconds top ignore writes
// [RQ3] Inhibit bit stops advancement; clearing resumes it
// [RQ4] Software inhibits, loads ten bytes, sets format
// [RQ5] Software keeps ten bytes in one format
// [RQ6] Advancement follows the selected data format
// [RQ7] Hour mode 12 or 24; PM top bit
// [RQ8] Software rewrites hours when hour mode changes
// [RQ9] Once per second advance; time reads undefined
// [RQ10] Lockout 248 or 1948 microseconds by base
// [RQ11] Hours, minutes, seconds match raises alarm
// [RQ12] Alarm byte with top bits set matches all
// [RQ13] Match-all codes give hourly, minutely, secondly alarms
// [RQ14] Field ranges: seconds through year limits
// [RQ15] General RAM accessible even during update
// [RQ16] Divider reset stops events; inhibit does not
// [RQ17] Held dividers leave time bytes as storage
// [RQ18] Bus lockout input blocks every access
// [RQ19] Flag read clears seen flags, keeps new
// [RQ20] Divider release gives first update half second later
// [RQ21] Carries through calendar with month lengths, leap
// [RQ22] Seconds top bit reads zero except while busy, when time bytes return all ones
`default_nettype none
`include "rtc_map.svh"
module rtc_core
    import rtc_pkg::*;
#(
    parameter int unsigned SEC_CYCLES = `RTC_SEC_CYCLES,
    parameter int unsigned LOCK_SLOW_CYCLES = `RTC_LOCK_SLOW_CYCLES
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic AS,
    input wire logic DS,
    input wire logic RW,
    input wire logic CS_N,
    input wire logic BUS_LOCKOUT_INPUT_N,
    input wire logic [7:0] AD_IN,
    output logic [7:0] AD_OUT,
    output logic AD_OE,
    output logic IRQ_N,
    output logic SQUARE_WAVE_OUTPUT
);
    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [7:0] time_mem [0:`RTC_TIME_BYTES-1];
    logic [7:0] ram_mem [`RTC_RAM_FIRST:`RTC_RAM_LAST];
    logic [6:0] reg_a_reg;
    logic [7:0] reg_b_reg;
    logic alarm_flag_reg;
    logic update_flag_reg;

    // ------------------------------------------------------------------
    // Bus front end
    // ------------------------------------------------------------------
    logic as_d_reg;
    logic ds_d_reg;
    logic [7:0] ad_d_reg;
    logic [5:0] addr_reg;
    logic access_ok;
    logic as_fall;
    logic ds_fall;
    logic wr_stb;
    logic rd_end;
    logic [7:0] rd_mux;

    // [RQ18] Lockout gates strobes
    assign access_ok = !CS_N && BUS_LOCKOUT_INPUT_N;
    assign as_fall = as_d_reg && !AS && access_ok;
    assign ds_fall = ds_d_reg && !DS && access_ok;
    assign wr_stb = ds_fall && !RW;
    assign rd_end = ds_fall && RW;
    assign AD_OE = DS && RW && access_ok;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            as_d_reg <= 1'b0;
            ds_d_reg <= 1'b0;
            ad_d_reg <= 8'h00;
        end else begin
            as_d_reg <= AS;
            ds_d_reg <= DS;
            ad_d_reg <= AD_IN;
        end
    end

    // Address is taken on the falling address strobe
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            addr_reg <= 6'h00;
        end else if (as_fall) begin
            addr_reg <= AD_IN[5:0];
        end
    end

    // ------------------------------------------------------------------
    // Divider chain and update sequencer
    // ------------------------------------------------------------------
    logic [23:0] pre_reg;
    logic div_reset;
    logic tick;
    logic set_bit;
    logic fmt_bin;
    logic [14:0] lock_cnt_reg;
    logic [14:0] lock_len;
    upd_state_t upd_state_reg;
    logic upd_busy;
    logic apply;

    assign div_reset = (reg_a_reg[6:5] == 2'h3);
    assign set_bit = reg_b_reg[`RTC_B_SET];
    assign fmt_bin = reg_b_reg[`RTC_B_FMT];
    // [RQ16] No second ticks while the divider is held
    assign tick = !div_reset && (pre_reg == 24'(SEC_CYCLES - 1));
    assign upd_busy = (upd_state_reg != UPD_IDLE);
    assign apply = (upd_state_reg == UPD_APPLY);
    // [RQ10] Lockout length by time base
    assign lock_len = (reg_a_reg[6:4] == `RTC_DV_SLOW) ? 15'(LOCK_SLOW_CYCLES - 1)
                                                      : 15'(`RTC_LOCK_FAST_CYCLES - 1);

    // [RQ20] Held divider parks at mid-second
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            pre_reg <= 24'(SEC_CYCLES / 2);
        end else if (div_reset) begin
            pre_reg <= 24'(SEC_CYCLES / 2);
        end else if (tick) begin
            pre_reg <= 24'h000000;
        end else begin
            pre_reg <= pre_reg + 24'h000001;
        end
    end

    // [RQ3] Inhibit blocks and aborts an update
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            upd_state_reg <= UPD_IDLE;
            lock_cnt_reg <= 15'h0000;
        end else begin
            case (upd_state_reg)
                UPD_IDLE: begin
                    // [RQ9] One update per second tick
                    if (tick && !set_bit) begin
                        upd_state_reg <= UPD_LOCK;
                        lock_cnt_reg <= lock_len;
                    end
                end
                UPD_LOCK: begin
                    if (set_bit) begin
                        upd_state_reg <= UPD_IDLE;
                    end else if (lock_cnt_reg == 15'h0000) begin
                        upd_state_reg <= UPD_APPLY;
                    end else begin
                        lock_cnt_reg <= lock_cnt_reg - 15'h0001;
                    end
                end
                UPD_APPLY: begin
                    upd_state_reg <= UPD_IDLE;
                end
                default: begin
                    upd_state_reg <= UPD_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Time advance
    // ------------------------------------------------------------------
    logic [7:0] sec_next;
    logic [7:0] min_next;
    logic [7:0] wday_next;
    logic [7:0] date_next;
    logic [7:0] month_next;
    logic [7:0] year_next;
    logic sec_wrap;
    logic min_wrap;
    logic date_wrap;
    logic month_wrap;
    logic [7:0] hr_next;
    logic day_carry;
    logic [6:0] dim;
    logic [6:0] month_b;
    logic [6:0] year_b;
    logic [7:0] n_sec;
    logic [7:0] n_min;
    logic [7:0] n_hr;

    // [RQ14] Field limits
    rtc_field_step u_sec (.val(time_mem[0]), .bin(fmt_bin), .lo(7'd0), .hi(7'd59),
        .next(sec_next), .wrap(sec_wrap));
    rtc_field_step u_min (.val(time_mem[2]), .bin(fmt_bin), .lo(7'd0), .hi(7'd59),
        .next(min_next), .wrap(min_wrap));
    rtc_field_step u_wday (.val(time_mem[6]), .bin(fmt_bin), .lo(7'd1), .hi(7'd7),
        .next(wday_next), .wrap());
    rtc_field_step u_date (.val(time_mem[7]), .bin(fmt_bin), .lo(7'd1), .hi(dim),
        .next(date_next), .wrap(date_wrap));
    rtc_field_step u_month (.val(time_mem[8]), .bin(fmt_bin), .lo(7'd1), .hi(7'd12),
        .next(month_next), .wrap(month_wrap));
    rtc_field_step u_year (.val(time_mem[9]), .bin(fmt_bin), .lo(7'd0), .hi(7'd99),
        .next(year_next), .wrap());

    // [RQ21] Month length and leap year; year 00 counts as leap
    assign month_b = to_bin(time_mem[8], fmt_bin);
    assign year_b = to_bin(time_mem[9], fmt_bin);
    always_comb begin
        dim = 7'd31;
        if (month_b == 7'd2) begin
            dim = (year_b[1:0] == 2'h0) ? 7'd29 : 7'd28;
        end else if (month_b == 7'd4 || month_b == 7'd6 || month_b == 7'd9 || month_b == 7'd11) begin
            dim = 7'd30;
        end
    end

    // [RQ7] Hour step in 12 or 24 hour mode
    always_comb begin
        logic [6:0] hb;
        logic [7:0] enc;
        hb = to_bin({1'b0, time_mem[4][6:0]}, fmt_bin);
        enc = 8'h00;
        hr_next = 8'h00;
        day_carry = 1'b0;
        if (reg_b_reg[`RTC_B_H24]) begin
            day_carry = (hb >= 7'd23);
            hr_next = from_bin(day_carry ? 7'd0 : 7'(hb + 7'd1), fmt_bin);
        end else begin
            enc = from_bin((hb >= 7'd12) ? 7'd1 : 7'(hb + 7'd1), fmt_bin);
            day_carry = (hb == 7'd11) && time_mem[4][7];
            hr_next = {time_mem[4][7] ^ (hb == 7'd11), enc[6:0]};
        end
    end

    // [RQ6] Carries chain in the chosen format
    assign n_sec = sec_next;
    assign n_min = sec_wrap ? min_next : time_mem[2];
    assign n_hr = (sec_wrap && min_wrap) ? hr_next : time_mem[4];

    // [RQ17] Time bytes change only by writes or updates
    always_ff @(posedge CLK) begin
        if (apply) begin
            time_mem[0] <= n_sec;
            time_mem[2] <= n_min;
            time_mem[4] <= n_hr;
            if (sec_wrap && min_wrap && day_carry) begin
                time_mem[6] <= wday_next;
                time_mem[7] <= date_next;
                if (date_wrap) begin
                    time_mem[8] <= month_next;
                    if (month_wrap) begin
                        time_mem[9] <= year_next;
                    end
                end
            end
        end else if (wr_stb && addr_reg < 6'(`RTC_TIME_BYTES)) begin
            // [RQ22] Seconds top bit reads zero
            // [RQ2] Seconds top bit is not storable
            if (addr_reg == `RTC_OFS_SEC) begin
                time_mem[0] <= {1'b0, ad_d_reg[6:0]};
            end else begin
                time_mem[addr_reg[3:0]] <= ad_d_reg;
            end
        end
    end

    // [RQ15] RAM bytes never locked out
    always_ff @(posedge CLK) begin
        if (wr_stb && addr_reg >= 6'(`RTC_RAM_FIRST)) begin
            ram_mem[addr_reg] <= ad_d_reg;
        end
    end

    // ------------------------------------------------------------------
    // Alarm
    // ------------------------------------------------------------------
    logic sec_hit;
    logic min_hit;
    logic hr_hit;
    logic alarm_hit;

    // [RQ12] Match-all code per byte
    rtc_alarm_cmp u_sec_alm (.alarm(time_mem[1]), .count(n_sec), .match(sec_hit));
    rtc_alarm_cmp u_min_alm (.alarm(time_mem[3]), .count(n_min), .match(min_hit));
    rtc_alarm_cmp u_hr_alm (.alarm(time_mem[5]), .count(n_hr), .match(hr_hit));
    // [RQ13] All three must agree
    assign alarm_hit = sec_hit && min_hit && hr_hit;

    // ------------------------------------------------------------------
    // Control registers and flags
    // ------------------------------------------------------------------
    logic c_read;
    logic [7:0] clr_mask;
    logic irq_flag;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            reg_a_reg <= `RTC_A_RESET;
            reg_b_reg <= `RTC_B_RESET;
        end else if (wr_stb) begin
            // [RQ2] Busy bit of A is not written
            if (addr_reg == `RTC_OFS_A) begin
                reg_a_reg <= ad_d_reg[6:0];
            end
            if (addr_reg == `RTC_OFS_B) begin
                reg_b_reg <= ad_d_reg;
            end
        end
    end

    // [RQ19] Clear what was shown; new events win
    assign c_read = rd_end && (addr_reg == `RTC_OFS_C);
    assign clr_mask = c_read ? AD_OUT : 8'h00;
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            alarm_flag_reg <= 1'b0;
            update_flag_reg <= 1'b0;
        end else begin
            // [RQ11] Flag set on matching update
            alarm_flag_reg <= (alarm_flag_reg && !clr_mask[5]) || (apply && alarm_hit);
            update_flag_reg <= (update_flag_reg && !clr_mask[4]) || apply;
        end
    end

    // [RQ11] Interrupt only with its enable
    assign irq_flag = (alarm_flag_reg && reg_b_reg[`RTC_B_AIE])
                   || (update_flag_reg && reg_b_reg[`RTC_B_UIE]);

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // [RQ1] Full sixty-four byte decode
    always_comb begin
        rd_mux = 8'h00;
        if (addr_reg < 6'(`RTC_TIME_BYTES)) begin
            // [RQ9] Time bytes undefined while busy
            rd_mux = upd_busy ? `RTC_UNDEF_DATA : time_mem[addr_reg[3:0]];
        end else if (addr_reg == `RTC_OFS_A) begin
            rd_mux = {upd_busy, reg_a_reg};
        end else if (addr_reg == `RTC_OFS_B) begin
            rd_mux = reg_b_reg;
        end else if (addr_reg == `RTC_OFS_C) begin
            rd_mux = {irq_flag, 1'b0, alarm_flag_reg, update_flag_reg, 4'h0};
        end else if (addr_reg == `RTC_OFS_D) begin
            rd_mux = `RTC_D_VALUE;
        end else begin
            rd_mux = ram_mem[addr_reg];
        end
    end

    // Frozen from the strobe's rise so the flag snapshot stays stable
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            AD_OUT <= 8'h00;
        end else if (!DS) begin
            AD_OUT <= rd_mux;
        end
    end

    // ------------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------------
    // [RQ16] Square wave stops with the divider, not with inhibit
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            SQUARE_WAVE_OUTPUT <= 1'b0;
            IRQ_N <= 1'b1;
        end else begin
            SQUARE_WAVE_OUTPUT <= reg_b_reg[`RTC_B_SQ_EN] && !div_reset && (pre_reg < 24'(SEC_CYCLES / 2));
            IRQ_N <= !irq_flag;
        end
    end
endmodule : rtc_core
`default_nettype wire

// ==== rtc_core_monitor.sv ====
// Port checks for the clock core, bound to every instance
`default_nettype none
module rtc_core_monitor (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic AS,
    input wire logic DS,
    input wire logic RW,
    input wire logic CS_N,
    input wire logic BUS_LOCKOUT_INPUT_N,
    input wire logic [7:0] AD_IN,
    input wire logic [7:0] AD_OUT,
    input wire logic AD_OE,
    input wire logic IRQ_N,
    input wire logic SQUARE_WAVE_OUTPUT
);
    logic [5:0] addr_reg;
    logic rd;
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Address as strobed; no reset needed, only read under strobe
    always_ff @(posedge CLK) begin
        if (AS) begin
            addr_reg <= AD_IN[5:0];
        end
    end
    assign rd = DS && RW && !CS_N && BUS_LOCKOUT_INPUT_N;
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_OE_EQ: assert property (AD_OE == rd)
        else $error("bus drive enable wrong");
    AST_OE_LOCK: assert property (!BUS_LOCKOUT_INPUT_N |-> !AD_OE)
        else $error("bus driven under lockout");
    AST_OUT_HOLD: assert property (DS && $past(DS) |-> $stable(AD_OUT))
        else $error("read data moved in strobe");
    AST_IRQ_MIN: assert property ($fell(IRQ_N) |=> !IRQ_N [*2])
        else $error("interrupt dropped early");
    AST_IRQ_CLR: assert property ($fell(DS) && $past(rd) && addr_reg == 6'h0c |-> ##[1:2] IRQ_N)
        else $error("interrupt kept after flag read");
    AST_D_CONST: assert property (rd && $past(rd) && addr_reg == 6'h0d |-> AD_OUT == 8'h80)
        else $error("status byte wrong");
    AST_C_IRQF: assert property (rd && $past(rd) && addr_reg == 6'h0c && AD_OUT[7] |-> AD_OUT[5] || AD_OUT[4])
        else $error("summary flag without cause");
    AST_SEC_TOP: assert property (rd && $past(rd) && addr_reg == 6'h00 && AD_OUT != 8'hff |-> !AD_OUT[7])
        else $error("seconds top bit set");
    AST_SQW_HALF: assert property ($rose(SQUARE_WAVE_OUTPUT) |=> SQUARE_WAVE_OUTPUT [*8])
        else $error("square wave pulse short");
    COV_IRQ: cover property ($fell(IRQ_N));
    COV_CLR: cover property ($fell(DS) && addr_reg == 6'h0c && !IRQ_N);
    COV_SQW: cover property ($rose(SQUARE_WAVE_OUTPUT));
endmodule : rtc_core_monitor

bind rtc_core rtc_core_monitor MON (.CLK(CLK), .RESET(RESET), .AS(AS), .DS(DS), .RW(RW), .CS_N(CS_N),
    .BUS_LOCKOUT_INPUT_N(BUS_LOCKOUT_INPUT_N), .AD_IN(AD_IN), .AD_OUT(AD_OUT), .AD_OE(AD_OE),
    .IRQ_N(IRQ_N), .SQUARE_WAVE_OUTPUT(SQUARE_WAVE_OUTPUT));
`default_nettype wire

// ==== rtc_host_model.sv ====
// Host processor on the multiplexed address/data bus
`default_nettype none
module rtc_host_model (
    input wire logic clk,
    output logic as_p,
    output logic ds_p,
    output logic rw_p,
    output logic cs_n,
    output logic [7:0] ad_in,
    input wire logic [7:0] ad_out,
    input wire logic ad_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        as_p = 1'b0;
        ds_p = 1'b0;
        rw_p = 1'b1;
        cs_n = 1'b1;
        ad_in = 8'h00;
    end
    // ------------------------------------------------------------
    // Byte cycle
    // ------------------------------------------------------------
    // Extra low cycle before the strobe lets read data settle
    task automatic access(input logic [5:0] a, input logic rd, input logic [7:0] wd, output logic [7:0] q);
        @(posedge clk);
        as_p <= 1'b1;
        cs_n <= 1'b0;
        ad_in <= {2'h0, a};
        @(posedge clk);
        as_p <= 1'b0;
        @(posedge clk);
        @(posedge clk);
        ds_p <= 1'b1;
        rw_p <= rd;
        ad_in <= rd ? ~ad_in : wd;
        @(posedge clk);
        #1 q = ad_oe ? ad_out : ~ad_in;
        @(posedge clk);
        ds_p <= 1'b0;
        // Released bus shows the inverse, never a stale copy
        @(posedge clk);
        cs_n <= 1'b1;
        rw_p <= 1'b1;
        ad_in <= ~ad_in;
    endtask : access
endmodule : rtc_host_model
`default_nettype wire

// ==== rtc_core_tb.sv ====
// Self-checking bench for the clock core map
`default_nettype none
module rtc_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SEC = 2000;
    localparam int LOCK = 200;
    logic clk = 1'b0;
    logic reset;
    logic lockout_n;
    logic as_p, ds_p, rw_p, cs_n, ad_oe, irq_n, square_wave_output;
    logic [7:0] ad_in, ad_out;
    int n_fail = 0;
    int compares = 0;
    int cycles = 0;
    logic [5:0] ro_a [4] = '{6'h0c, 6'h0d, 6'h0a, 6'h00};
    logic [7:0] ro_w [4] = '{8'hff, 8'h00, 8'ha0, 8'hd9};
    logic [7:0] ro_e [4] = '{8'h00, 8'h80, 8'h20, 8'h59};
    logic [7:0] mode [3] = '{8'h02, 8'h04, 8'h02};
    logic [7:0] init_v [3][10] = '{'{8'h59, 8'h00, 8'h59, 8'h00, 8'h23, 8'h00, 8'h07, 8'h31, 8'h12, 8'h99},
        '{8'h3b, 8'hc0, 8'h3b, 8'hc0, 8'h8b, 8'hc0, 8'h03, 8'h1c, 8'h02, 8'h01},
        '{8'h59, 8'h00, 8'h59, 8'h00, 8'h23, 8'hff, 8'h02, 8'h28, 8'h02, 8'h00}};
    logic [7:0] exp_v [3][10] = '{'{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00},
        '{8'h00, 8'hc0, 8'h00, 8'hc0, 8'h0c, 8'hc0, 8'h04, 8'h01, 8'h03, 8'h01},
        '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h03, 8'h29, 8'h02, 8'h00}};
    always #50 clk = ~clk;
    rtc_host_model HOST (.clk(clk), .as_p(as_p), .ds_p(ds_p), .rw_p(rw_p), .cs_n(cs_n), .ad_in(ad_in),
        .ad_out(ad_out), .ad_oe(ad_oe));
    rtc_core #(.SEC_CYCLES(SEC), .LOCK_SLOW_CYCLES(LOCK)) DUT (.CLK(clk), .RESET(reset), .AS(as_p),
        .DS(ds_p), .RW(rw_p), .CS_N(cs_n), .BUS_LOCKOUT_INPUT_N(lockout_n), .AD_IN(ad_in),
        .AD_OUT(ad_out), .AD_OE(ad_oe), .IRQ_N(irq_n), .SQUARE_WAVE_OUTPUT(square_wave_output));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask : chk
    task automatic chk_cnt(input string what, input int lo, input int hi, input int g);
        compares++;
        if (g < lo || g > hi) begin
            n_fail++;
            $display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, g);
        end
    endtask : chk_cnt
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] q;
        HOST.access(a, 1'b0, d, q);
    endtask : wr
    task automatic rd_chk(input string what, input logic [5:0] a, input logic [7:0] e);
        logic [7:0] q;
        HOST.access(a, 1'b1, 8'h00, q);
        chk(what, e, q);
    endtask : rd_chk
    // Bounded wait; a dead interrupt shows as a bad count
    task automatic wait_irq(output int n);
        n = 0;
        while (irq_n !== 1'b0 && n < 4 * SEC) begin
            @(posedge clk);
            n++;
        end
    endtask : wait_irq
    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_fail++;
            final_report();
        end
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        int n;
        logic [7:0] q;
        reset = 1'b1;
        lockout_n = 1'b1;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        rd_chk("reg a", 6'h0a, 8'h20);
        rd_chk("reg b", 6'h0b, 8'h02);
        rd_chk("reg c", 6'h0c, 8'h00);
        rd_chk("reg d", 6'h0d, 8'h80);
        wr(6'h0b, 8'h82);
        for (int k = 0; k < 4; k++) begin
            wr(ro_a[k], ro_w[k]);
            rd_chk("read-only", ro_a[k], ro_e[k]);
        end
        $display("test read-only done");
        for (int a = 14; a < 64; a++) wr(6'(a), 8'(a) ^ 8'h5a);
        lockout_n <= 1'b0;
        wr(6'h20, 8'h00);
        lockout_n <= 1'b1;
        for (int a = 14; a < 64; a++) rd_chk("ram", 6'(a), 8'(a) ^ 8'h5a);
        $display("test ram done");
        for (int i = 0; i < 3; i++) begin
            wr(6'h0b, 8'h80 | mode[i]);
            for (int j = 0; j < 10; j++) wr(6'(j), init_v[i][j]);
            repeat (SEC + LOCK) @(posedge clk);
            rd_chk("seconds held", 6'h00, init_v[i][0]);
            wr(6'h0b, 8'h20 | mode[i]);
            n = 0;
            q = 8'h00;
            while (q[7] !== 1'b1 && n < 1000) begin
                HOST.access(6'h0a, 1'b1, 8'h00, q);
                n++;
            end
            rd_chk("time in update", 6'h00, 8'hff);
            wr(6'h21, 8'(i));
            rd_chk("ram in update", 6'h21, 8'(i));
            wait_irq(n);
            chk_cnt("lockout", LOCK - 40, LOCK + 5, n);
            for (int j = 0; j < 10; j++) rd_chk("time", 6'(j), exp_v[i][j]);
            rd_chk("flags", 6'h0c, 8'hb0);
            rd_chk("flags cleared", 6'h0c, 8'h00);
            chk("irq released", 8'h01, {7'h00, irq_n});
            $display("test calendar case %0d done", i);
        end
        wr(6'h0a, 8'h60);
        wr(6'h0b, 8'h18);
        for (int j = 0; j < 10; j++) wr(6'(j), 8'h40 + 8'(j));
        repeat (2 * SEC) @(posedge clk);
        chk("square held", 8'h00, {7'h00, square_wave_output});
        for (int j = 0; j < 10; j++) rd_chk("stored", 6'(j), 8'h40 + 8'(j));
        rd_chk("no events", 6'h0c, 8'h00);
        wr(6'h0a, 8'h20);
        wait_irq(n);
        chk_cnt("first update", SEC / 2 + LOCK - 15, SEC / 2 + LOCK + 15, n);
        repeat (SEC) @(posedge clk);
        $display("test divider hold done");
        final_report();
    end
endmodule : rtc_core_tb
`default_nettype wire
